// ---- core/spcg_map.vh ----
// Purpose: register map and field constants for the sleep and clock gating block
// Assumes: 8-bit registers on a plain strobe port, word index equals printed offset
// Notes:   sleep control sits in its own register space, selected by a space bit
`ifndef SPCG_MAP_VH
`define SPCG_MAP_VH

// address: bit 3 selects space (0 sleep, 1 power reduction), bits 2:0 offset
`define SPCG_ADDR_W        4
`define SPCG_SPACE_BIT     3
`define SPCG_SLEEP_CTRL    3'h0
`define SPCG_GEN_GATE      3'h0
`define SPCG_PORT_A_GATE   3'h1
`define SPCG_PORT_B_GATE   3'h2
`define SPCG_PORT_C_GATE   3'h3
`define SPCG_PORT_D_GATE   3'h4
`define SPCG_PORT_E_GATE   3'h5
`define SPCG_PORT_F_GATE   3'h6

// sleep control fields
`define SPCG_ARM_BIT       0
`define SPCG_MODE_LSB      1
`define SPCG_MODE_MSB      3
`define SPCG_CTRL_MASK     8'h0F

// writable masks per register kind
`define SPCG_GEN_MASK      8'h1F
`define SPCG_ANA_MASK      8'h07
`define SPCG_DIG_MASK      8'h7F

// general gate fields
`define SPCG_GEN_DMA       0
`define SPCG_GEN_EVENT     1
`define SPCG_GEN_RTC       2
`define SPCG_GEN_EBUS      3
`define SPCG_GEN_CIPHER    4

// sleep mode codes
`define SPCG_IDLE_CODE     3'h0
`define SPCG_POWER_DOWN_CODE_CODE    3'h2
`define SPCG_POWER_SAVE_CODE_CODE    3'h3
`define SPCG_STANDBY_CODE_CODE    3'h6
`define SPCG_EXTENDED_STANDBY_CODE_CODE   3'h7

// reset values
`define SPCG_RESET_VAL     8'h00

// wake halt length in cpu cycles
`define SPCG_WAKE_HALT     3'h4

`endif

// ---- core/spcg_gate.v ----
// Purpose: glitch-free clock enable for one gated peripheral
// Assumes: the gated clock cell samples the enable on the falling edge
// Notes:   enable changes only after a rising edge, so no short pulses
module spcg_gate (
	// clock and reset
	input  wire sys_clk,
	input  wire rstn,
	// control
	input  wire stop_req,
	// enable towards the clock gate cell
	output reg  clk_en_q
);

	// registered enable: changes only on rising edge, clean for a latch cell
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			clk_en_q <= 1'b1;
		end else begin
			clk_en_q <= ~stop_req;
		end
	end

endmodule

// ---- core/spcg_top.v ----
// Purpose: sleep mode control and per-peripheral clock gating
// Assumes: cpu pulses sleep_exec for one cycle on the sleep instruction
// Notes:   presence straps mark which peripherals exist; absent bits are inert
//
// Our own choice: strobed register access.
`include "spcg_map.vh"

// Function
// R1 - gated peripheral frozen, its register access blocked
// R2 - ungated peripheral resumes from frozen state
// R3 - gate bits of absent peripherals do nothing
// R4 - sleep mode field codes five modes
// R5 - sleep entered only when sleep arm set
// R6 - software arms just before sleep, clears after
// R7 - bit 4 stops cipher engine clock
// R8 - bit 3 stops external bus clock
// R9 - bit 2 stops rtc interface, counter runs
// R10 - bit 1 stops event routing, resumes after
// R11 - dma gate settable only while dma disabled
// R12 - analog ports gate dac adc comparator
// R13 - digital ports gate serial and fine resolution
// R14 - digital ports gate timers, resume after
// R15 - deep sleep stops all peripheral clocks
// R16 - software disables peripheral before gating
// R17 - deep sleep disables pin input buffers
// R18 - comparator off outside idle, reference kept
// R19 - adc stays enabled in every sleep mode
// R20 - watchdog keeps running in every sleep
// R21 - debug keeps main clock in sleep
// R22 - cpu held four cycles after wake
// R23 - power-down wake sources limited, save adds rtc
// R24 - idle stops cpu, all interrupts wake
// R25 - glitch-free clock enable per peripheral
module spcg_top (
	// clock and reset
	input  wire        sys_clk,
	input  wire        rstn,
	// register port
	input  wire [3:0]  reg_addr,
	input  wire [7:0]  reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [7:0]  reg_rdata,
	// cpu side
	input  wire        sleep_exec,
	output wire        cpu_clk_en,
	output wire        nvm_clk_en,
	output wire        cpu_halt,
	output wire        sleeping,
	output wire        wake_service,
	// wake sources, already synchronised interrupt levels
	input  wire        irq_any,
	input  wire        irq_twi_match,
	input  wire        irq_port_async,
	input  wire        irq_rtc,
	// peripheral state
	input  wire        dma_enabled,
	input  wire        ac_uses_vref,
	input  wire        debug_enabled,
	input  wire        wdt_enabled,
	input  wire        adc_enabled,
	input  wire [4:0]  gen_present,
	input  wire [5:0]  ana_present,
	input  wire [27:0] dig_present,
	// clock enables
	output wire [4:0]  gen_clk_en,
	output wire [5:0]  ana_clk_en,
	output wire [27:0] dig_clk_en,
	output wire        rtc_count_en,
	output wire        sys_osc_en,
	output wire        rtc_osc_en,
	// analog and pin control
	output wire        ac_force_off,
	output wire        vref_keep,
	output wire        adc_keep,
	output wire        adc_long_conv,
	output wire        wdt_run,
	output wire        pin_inbuf_en,
	// register access block per peripheral (high = blocked)
	output wire [4:0]  gen_io_block,
	output wire [5:0]  ana_io_block,
	output wire [27:0] dig_io_block
);

	// sleep controller states
	localparam ST_ACTIVE = 2'h0;
	localparam ST_SLEEP  = 2'h1;
	localparam ST_HALT   = 2'h2;

	// registers
	reg [3:0]  ctrl_q;          // sleep mode and arm
	reg [7:0]  gen_q;           // general gate
	reg [2:0]  ana_q [0:1];     // analog port gates
	reg [6:0]  dig_q [0:3];     // digital port gates
	reg [1:0]  state_q;         // sleep controller state
	reg [2:0]  mode_q;          // mode latched at sleep entry
	reg [2:0]  halt_cnt_q;      // post wake halt counter
	reg        wake_svc_q;      // wake interrupt to be serviced
	reg        adc_prev_q;      // adc enable one cycle ago
	reg        adc_long_q;      // next adc conversion is extended
	reg        strap_q;         // strap capture done

	// captured presence straps, taken after reset release
	reg [4:0]  gen_pres_q;
	reg [5:0]  ana_pres_q;
	reg [27:0] dig_pres_q;

	wire       space_pr = reg_addr[`SPCG_SPACE_BIT];
	wire [2:0] offs     = reg_addr[2:0];

	// digital port index from offset (used by write and read)
	function [1:0] dig_idx;
		input [2:0] o;
		begin
			dig_idx = o[1:0] + 2'h1;
		end
	endfunction

	// offset belongs to a digital port register
	function is_dig;
		input [2:0] o;
		begin
			is_dig = (o >= `SPCG_PORT_C_GATE) && (o <= `SPCG_PORT_F_GATE);
		end
	endfunction

	// reserved codes are treated as no sleep
	function mode_valid;
		input [2:0] m;
		begin
			mode_valid = (m == `SPCG_IDLE_CODE) || (m == `SPCG_POWER_DOWN_CODE_CODE) ||
			             (m == `SPCG_POWER_SAVE_CODE_CODE) || (m == `SPCG_STANDBY_CODE_CODE) ||
			             (m == `SPCG_EXTENDED_STANDBY_CODE_CODE);
		end
	endfunction

	// strap capture at the first edge after reset release
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			strap_q    <= 1'b0;
			gen_pres_q <= 5'h00;
			ana_pres_q <= 6'h00;
			dig_pres_q <= 28'h0000000;
		end else if (!strap_q) begin
			strap_q    <= 1'b1;
			gen_pres_q <= gen_present;
			ana_pres_q <= ana_present;
			dig_pres_q <= dig_present;
		end
	end

	// register writes
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_q   <= 4'h0;
			gen_q    <= `SPCG_RESET_VAL;
			ana_q[0] <= 3'h0;
			ana_q[1] <= 3'h0;
			dig_q[0] <= 7'h00;
			dig_q[1] <= 7'h00;
			dig_q[2] <= 7'h00;
			dig_q[3] <= 7'h00;
		end else if (reg_wr) begin
			if (!space_pr) begin
				// R4 mode field stored
				if (offs == `SPCG_SLEEP_CTRL)
					ctrl_q <= reg_wdata[3:0];
			end else if (offs == `SPCG_GEN_GATE) begin
				gen_q <= reg_wdata & `SPCG_GEN_MASK;
				// R11 dma gate refused while enabled
				if (dma_enabled && !gen_q[`SPCG_GEN_DMA])
					gen_q[`SPCG_GEN_DMA] <= 1'b0;
			end else if (offs == `SPCG_PORT_A_GATE || offs == `SPCG_PORT_B_GATE) begin
				ana_q[offs[1] ? 1 : 0] <= reg_wdata[2:0];
			end else if (is_dig(offs)) begin
				dig_q[dig_idx(offs)] <= reg_wdata[6:0];
			end
		end
	end

	// read data, one cycle after the strobe; unmapped reads zero
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			if (!space_pr)
				reg_rdata <= (offs == `SPCG_SLEEP_CTRL) ? {4'h0, ctrl_q} : 8'h00;
			else if (offs == `SPCG_GEN_GATE)
				reg_rdata <= gen_q;
			else if (offs == `SPCG_PORT_A_GATE || offs == `SPCG_PORT_B_GATE)
				reg_rdata <= {5'h00, ana_q[offs[1] ? 1 : 0]};
			else if (is_dig(offs))
				reg_rdata <= {1'b0, dig_q[dig_idx(offs)]};
			else
				reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// wake source qualified by the latched mode
	reg wake_ok;
	always @* begin
		wake_ok = 1'b0;
		case (mode_q)
			// R24 any enabled interrupt wakes idle
			`SPCG_IDLE_CODE:   wake_ok = irq_any;
			// R23 power-down and standby: twi match and async pins only
			`SPCG_POWER_DOWN_CODE_CODE,
			`SPCG_STANDBY_CODE_CODE:  wake_ok = irq_twi_match | irq_port_async;
			// R23 power-save adds the rtc
			`SPCG_POWER_SAVE_CODE_CODE,
			`SPCG_EXTENDED_STANDBY_CODE_CODE: wake_ok = irq_twi_match | irq_port_async | irq_rtc;
			default:           wake_ok = 1'b0;
		endcase
	end

	// sleep controller
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state_q    <= ST_ACTIVE;
			mode_q     <= `SPCG_IDLE_CODE;
			halt_cnt_q <= 3'h0;
			wake_svc_q <= 1'b0;
		end else begin
			wake_svc_q <= 1'b0;
			case (state_q)
				ST_ACTIVE: begin
					// R5 enter only when armed
					if (sleep_exec && ctrl_q[`SPCG_ARM_BIT] &&
					    mode_valid(ctrl_q[`SPCG_MODE_MSB:`SPCG_MODE_LSB])) begin
						state_q <= ST_SLEEP;
						mode_q  <= ctrl_q[`SPCG_MODE_MSB:`SPCG_MODE_LSB];
					end
				end
				ST_SLEEP: begin
					if (wake_ok) begin
						state_q    <= ST_HALT;
						halt_cnt_q <= `SPCG_WAKE_HALT - 3'h1;
					end
				end
				ST_HALT: begin
					// R22 four halted cycles then wake service
					if (halt_cnt_q == 3'h0) begin
						state_q    <= ST_ACTIVE;
						wake_svc_q <= 1'b1;
					end else begin
						halt_cnt_q <= halt_cnt_q - 3'h1;
					end
				end
				default: state_q <= ST_ACTIVE;
			endcase
		end
	end

	wire asleep    = (state_q == ST_SLEEP);
	wire deep      = asleep && (mode_q != `SPCG_IDLE_CODE);
	wire keep_osc  = (mode_q == `SPCG_STANDBY_CODE_CODE) || (mode_q == `SPCG_EXTENDED_STANDBY_CODE_CODE);
	wire keep_rtc  = (mode_q == `SPCG_POWER_SAVE_CODE_CODE) || (mode_q == `SPCG_EXTENDED_STANDBY_CODE_CODE);

	// R24 idle stops cpu and nvm
	assign cpu_clk_en   = ~asleep;
	assign nvm_clk_en   = ~asleep;
	assign cpu_halt     = (state_q != ST_ACTIVE);
	assign sleeping     = asleep;
	assign wake_service = wake_svc_q;
	// R21 debug keeps main clock running
	assign sys_osc_en   = ~deep | keep_osc | debug_enabled;
	assign rtc_osc_en   = ~deep | keep_rtc;
	// R9 rtc counter runs under its gate bit
	assign rtc_count_en = ~deep | keep_rtc;
	// R17 inputs off in deep sleep
	assign pin_inbuf_en = ~deep;
	// R18 comparator off outside idle, reference kept
	assign ac_force_off = deep;
	assign vref_keep    = ac_uses_vref;
	// R19 adc kept enabled in sleep
	assign adc_keep     = adc_enabled;
	// R20 watchdog unaffected by sleep
	assign wdt_run      = wdt_enabled;

	// R19 track adc off then on for extended conversion
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			adc_prev_q <= 1'b0;
			adc_long_q <= 1'b1;
		end else begin
			adc_prev_q <= adc_enabled;
			if (!adc_enabled)
				adc_long_q <= 1'b1;
			else if (adc_prev_q && adc_long_q && !deep)
				adc_long_q <= 1'b0;
		end
	end
	assign adc_long_conv = adc_long_q;

	// flatten gate bits; R3 absent peripherals masked out
	wire [4:0]  gen_stop = gen_q[4:0] & gen_pres_q;
	wire [5:0]  ana_stop = {ana_q[1], ana_q[0]} & ana_pres_q;
	wire [27:0] dig_stop = {dig_q[3], dig_q[2], dig_q[1], dig_q[0]} & dig_pres_q;
	// R15 deep sleep stops every peripheral clock
	wire [38:0] all_stop = {dig_stop, ana_stop, gen_stop} | {39{deep}};
	wire [38:0] all_en;

	// R25 one glitch-free enable per peripheral
	// R1 gated clock freezes state
	// R2 state kept, so resume is exact
	// R7 R8 R10 R12 R13 R14 mapped by bit position
	genvar gi;
	generate
		for (gi = 0; gi < 39; gi = gi + 1) begin : g_gate
			spcg_gate u_gate (
				.sys_clk  (sys_clk),
				.rstn     (rstn),
				.stop_req (all_stop[gi]),
				.clk_en_q (all_en[gi])
			);
		end
	endgenerate

	assign gen_clk_en = all_en[4:0];
	assign ana_clk_en = all_en[10:5];
	assign dig_clk_en = all_en[38:11];

	// R1 register access blocked while gated
	assign gen_io_block = gen_stop;
	assign ana_io_block = ana_stop;
	assign dig_io_block = dig_stop;

endmodule

// ---- tb/spcg_chk_sva.sv ----
// Purpose: port-level checks for the sleep and clock gating block
// Assumes: one clock domain, reset active low
// Notes:   deep sleep is seen as sleeping with input buffers off
module spcg_chk (
	// clock and reset
	input logic        sys_clk,
	input logic        rstn,
	// cpu side
	input logic        sleep_exec,
	input logic        cpu_clk_en,
	input logic        nvm_clk_en,
	input logic        cpu_halt,
	input logic        sleeping,
	input logic        wake_service,
	// wake sources and states
	input logic        irq_twi_match,
	input logic        irq_port_async,
	input logic        irq_rtc,
	input logic        wdt_enabled,
	// enables and blocks
	input logic [4:0]  gen_clk_en,
	input logic [5:0]  ana_clk_en,
	input logic [27:0] dig_clk_en,
	input logic        ac_force_off,
	input logic        wdt_run,
	input logic        pin_inbuf_en,
	input logic [4:0]  gen_io_block,
	input logic [27:0] dig_io_block
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	// a blocked digital or general peripheral must have lost its clock one cycle later
	property p_frozen;
		(($past(dig_io_block) & dig_clk_en) == 28'h0) && (($past(gen_io_block) & gen_clk_en) == 5'h0);
	endproperty
	a_frozen: assert property (p_frozen) else $error("blocked peripheral clock runs");
	property p_deep;
		$past(sleeping && !pin_inbuf_en) && sleeping && !pin_inbuf_en |-> ana_clk_en == 6'h0 && dig_clk_en == 28'h0;
	endproperty
	a_deep: assert property (p_deep) else $error("clock runs in deep sleep");
	property p_inbuf;
		!pin_inbuf_en |-> sleeping;
	endproperty
	a_inbuf: assert property (p_inbuf) else $error("input buffers off while awake");
	property p_acoff;
		ac_force_off == (sleeping && !pin_inbuf_en);
	endproperty
	a_acoff: assert property (p_acoff) else $error("comparator off mismatch");
	property p_enter;
		$rose(sleeping) |-> $past(sleep_exec);
	endproperty
	a_enter: assert property (p_enter) else $error("sleep without instruction");
	property p_halt;
		$rose(cpu_halt && !sleeping) |-> (cpu_halt && !sleeping)[*4] ##1 (wake_service && !cpu_halt);
	endproperty
	a_halt: assert property (p_halt) else $error("wake halt length wrong");
	property p_cpu;
		sleeping |-> !cpu_clk_en && !nvm_clk_en;
	endproperty
	a_cpu: assert property (p_cpu) else $error("cpu clock runs in sleep");
	property p_resume;
		$past(pin_inbuf_en && !gen_io_block[1]) |-> gen_clk_en[1];
	endproperty
	a_resume: assert property (p_resume) else $error("event clock not resumed");
	property p_wake;
		sleeping && !pin_inbuf_en && !irq_twi_match && !irq_port_async && !irq_rtc |=> sleeping;
	endproperty
	a_wake: assert property (p_wake) else $error("woke without wake source");
	property p_wdt;
		wdt_run == wdt_enabled;
	endproperty
	a_wdt: assert property (p_wdt) else $error("watchdog run mismatch");
endmodule

bind spcg_top spcg_chk chk (.*);

// ---- tb/spcg_cpu_model.sv ----
// Purpose: cpu and interrupt sources beside the sleep block
// Assumes: bench asks for sleep and interrupts by one-cycle pulses
// Notes:   interrupts stay pending until the wake service pulse
module spcg_cpu_model (
	// clock and reset
	input  logic       sys_clk,
	input  logic       rstn,
	// requests from the bench
	input  logic       sleep_req,
	input  logic [3:0] irq_req,
	// answer from the block
	input  logic       wake_service,
	// towards the block
	output logic       sleep_exec,
	output logic       irq_any,
	output logic       irq_twi_match,
	output logic       irq_port_async,
	output logic       irq_rtc
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] irq_q; // pending levels
	// sleep instruction pulse and pending interrupts
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			sleep_exec <= 1'b0;
			irq_q <= 4'h0;
		end else begin
			sleep_exec <= sleep_req;
			irq_q <= wake_service ? 4'h0 : (irq_q | irq_req);
		end
	end
	assign {irq_rtc, irq_port_async, irq_twi_match, irq_any} = irq_q;
endmodule

// ---- tb/tb.sv ----
// Purpose: register, gating and sleep tests for the sleep block
// Assumes: ebus strap absent, all other peripherals present
// Notes:   addresses 8 to 15 are the power reduction space
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic sys_clk, rstn, reg_wr, reg_rd, sleep_req, v;
	logic dma_enabled, wdt_enabled, adc_enabled, debug_enabled, ac_uses_vref;
	logic [3:0] reg_addr, irq_req;
	logic [7:0] reg_wdata, reg_rdata;
	logic sleep_exec, irq_any, irq_twi_match, irq_port_async, irq_rtc;
	logic cpu_clk_en, nvm_clk_en, cpu_halt, sleeping, wake_service, rtc_count_en;
	logic sys_osc_en, rtc_osc_en, ac_force_off, vref_keep, adc_keep, adc_long_conv;
	logic wdt_run, pin_inbuf_en;
	logic [4:0] gen_present, gen_clk_en, gen_io_block;
	logic [5:0] ana_present, ana_clk_en, ana_io_block;
	logic [27:0] dig_present, dig_clk_en, dig_io_block;
	int failures, checks_done, cyc;
	spcg_top dut (.*);
	spcg_cpu_model cpu (.*);
	// free running clock
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	task automatic chk(input string n, input logic [27:0] e, input logic [27:0] s);
		checks_done++;
		if (s !== e) begin
			failures++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		chk("rdata", 28'(e), 28'(reg_rdata));
	endtask
	// sleep instruction, then let the entry settle
	task automatic nap;
		@(posedge sys_clk);
		sleep_req <= 1'b1;
		@(posedge sys_clk);
		sleep_req <= 1'b0;
		tick(3);
	endtask
	task automatic stop_test;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// hang guard, run needs well under a thousand cycles
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			failures++;
			stop_test;
		end
	end
	initial begin
		rstn = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 4'h0; reg_wdata = 8'h00;
		sleep_req = 1'b0; irq_req = 4'h0; dma_enabled = 1'b0; wdt_enabled = 1'b1;
		adc_enabled = 1'b0; debug_enabled = 1'b0; ac_uses_vref = 1'b0;
		gen_present = 5'h17; ana_present = 6'h3F; dig_present = 28'hFFFFFFF;
		repeat (3) @(posedge sys_clk);
		rstn <= 1'b1;
		tick(2);
		for (int a = 0; a < 16; a++) rd(4'(a), 8'h00);
		chk("dig_en", 28'hFFFFFFF, dig_clk_en);
		$display("test reset done");
		wr(4'h0, 8'hFF);
		rd(4'h0, 8'h0F);
		wr(4'h9, 8'hFF);
		rd(4'h9, 8'h07);
		wr(4'hB, 8'hFF);
		rd(4'hB, 8'h7F);
		wr(4'hF, 8'hFF);
		rd(4'hF, 8'h00);
		chk("ana_en", 28'h38, 28'(ana_clk_en));
		chk("dig_en", 28'hFFFFF80, dig_clk_en);
		chk("dig_blk", 28'h7F, dig_io_block);
		chk("ana_blk", 28'h07, 28'(ana_io_block));
		wr(4'hB, 8'h00);
		wr(4'h9, 8'h00);
		wr(4'h0, 8'h00);
		tick(1);
		chk("dig_en", 28'hFFFFFFF, dig_clk_en);
		$display("test ports done");
		dma_enabled <= 1'b1;
		wr(4'h8, 8'h1F);
		tick(2);
		chk("gen_blk", 28'h16, 28'(gen_io_block));
		chk("gen_en", 28'h09, 28'(gen_clk_en));
		chk("rtc_cnt", 28'h1, 28'(rtc_count_en));
		dma_enabled <= 1'b0;
		wr(4'h8, 8'h01);
		tick(2);
		chk("gen_blk", 28'h01, 28'(gen_io_block));
		chk("gen_en", 28'h1E, 28'(gen_clk_en));
		wr(4'h8, 8'h00);
		$display("test general done");
		wr(4'h0, 8'h04);
		nap;
		chk("sleeping", 28'h0, 28'(sleeping));
		for (int m = 0; m < 8; m++) begin
			wr(4'h0, {4'h0, 3'(m), 1'b1});
			nap;
			v = m inside {0, 2, 3, 6, 7};
			chk("sleeping", 28'(v), 28'(sleeping));
			if (v) begin
				chk("inbuf", 28'(m == 0), 28'(pin_inbuf_en));
				chk("ac_off", 28'(m != 0), 28'(ac_force_off));
				chk("dig_en", m == 0 ? 28'hFFFFFFF : 28'h0, dig_clk_en);
				chk("wdt", 28'h1, 28'(wdt_run));
				chk("sys_osc", 28'(m == 0 || m >= 6), 28'(sys_osc_en));
				chk("rtc_osc", 28'(m == 0 || m == 3 || m == 7), 28'(rtc_osc_en));
				chk("rtc_cnt", 28'(m == 0 || m == 3 || m == 7), 28'(rtc_count_en));
				irq_req <= 4'h1;
				tick(1);
				irq_req <= 4'h0;
				if (m != 0) begin
					tick(3);
					chk("sleeping", 28'h1, 28'(sleeping));
					irq_req <= 4'h4;
					tick(1);
					irq_req <= 4'h0;
				end
				for (int n = 0; n < 20 && wake_service !== 1'b1; n++) tick(1);
				chk("wake", 28'h1, 28'(wake_service));
				wr(4'h0, 8'h00);
			end
		end
		$display("test sleep done");
		// adc off then on asks for an extended conversion
		adc_enabled <= 1'b1;
		tick(2);
		chk("adc_long", 28'h0, 28'(adc_long_conv));
		adc_enabled <= 1'b0;
		tick(1);
		chk("adc_long", 28'h1, 28'(adc_long_conv));
		// power-down with debug, reference and adc kept alive
		debug_enabled <= 1'b1;
		ac_uses_vref <= 1'b1;
		adc_enabled <= 1'b1;
		wdt_enabled <= 1'b0;
		wr(4'h0, 8'h05);
		nap;
		chk("sleeping", 28'h1, 28'(sleeping));
		chk("sys_osc", 28'h1, 28'(sys_osc_en));
		chk("rtc_osc", 28'h0, 28'(rtc_osc_en));
		chk("vref", 28'h1, 28'(vref_keep));
		chk("adc_keep", 28'h1, 28'(adc_keep));
		chk("wdt", 28'h0, 28'(wdt_run));
		irq_req <= 4'h2;
		tick(1);
		irq_req <= 4'h0;
		for (int n = 0; n < 20 && wake_service !== 1'b1; n++) tick(1);
		chk("wake", 28'h1, 28'(wake_service));
		wr(4'h0, 8'h00);
		$display("test analog done");
		stop_test;
	end
endmodule
